// file: rtl/light_prox_defs.svh
`ifndef LIGHT_PROX_DEFS_SVH
`define LIGHT_PROX_DEFS_SVH

// ****************************************
// Register offsets
// ****************************************
`define REG_STATUS 8'h00
`define REG_MAIN_CFG 8'h01
`define REG_RX_CFG 8'h02
`define REG_LED_CFG 8'h03
`define REG_AMB_HI 8'h04
`define REG_AMB_LO 8'h05
`define REG_UP_HI 8'h06
`define REG_UP_LO 8'h07
`define REG_LO_HI 8'h08
`define REG_LO_LO 8'h09
`define REG_PERSIST 8'h0a
`define REG_PROX_DIR 8'h0b
`define REG_PROX_LIM 8'h0c
`define REG_TRIM_G 8'h0f
`define REG_TRIM_IR 8'h10
`define REG_PROX_RES 8'h16

// ****************************************
// Reset values and field positions
// ****************************************
`define MAIN_CFG_RESET 8'h24
`define TRIM_RESET 8'h80
`define ZERO_RESET 8'h00
`define MAIN_AMB_IE 0
`define MAIN_PROX_IE 1
`define MAIN_MODE_LSB 2
`define MAIN_TRIM_SEL 5
`define AMB_OFL_BIT 6
`define PERSIST_AMB_LSB 0
`define PERSIST_PROX_LSB 2
`define PROX_DIR_BIT 6

// ****************************************
// Persist counts and timing
// ****************************************
`define PERSIST_N0 5'd1
`define PERSIST_N1 5'd2
`define PERSIST_N2 5'd4
`define PERSIST_N3 5'd16
`define ADC_CLK_NS 125
`define AMB_T0_NS 100000000
`define AMB_T1_NS 25000000
`define AMB_T2_NS 6250000
`define AMB_T3_NS 1562500

`endif

// file: rtl/light_prox_pkg.sv
package light_prox_pkg;

   typedef enum logic [2:0] {
      MODE_SHUTDOWN = 3'b000,
      MODE_AMB_DIFF = 3'b001,
      MODE_AMB_GREEN = 3'b010,
      MODE_AMB_IR = 3'b011,
      MODE_AMB_PROX = 3'b100,
      MODE_PROX_ONLY = 3'b101,
      MODE_RSVD6 = 3'b110,
      MODE_RSVD7 = 3'b111
   } mode_t;

   typedef enum logic [3:0] {
      I2C_IDLE = 4'b0000,
      I2C_ADDR = 4'b0001,
      I2C_ADDR_ACK = 4'b0010,
      I2C_PTR = 4'b0011,
      I2C_PTR_ACK = 4'b0100,
      I2C_WR = 4'b0101,
      I2C_WR_ACK = 4'b0110,
      I2C_RD = 4'b0111,
      I2C_RD_ACK = 4'b1000
   } i2c_state_t;

   typedef struct packed {
      logic [13:0] green;
      logic [13:0] ir;
      logic ovf;
      logic [7:0] prox;
      logic amb_valid;
      logic prox_valid;
   } fe_result_t;

   typedef struct packed {
      mode_t mode;
      logic [1:0] ambient_conv_time_sel;
      logic [1:0] ambient_gain_sel;
      logic [3:0] led_current_code;
      logic led_enable;
      logic [6:0] green_trim;
      logic [8:0] infrared_channel_trim;
      logic factory_trim;
   } fe_cfg_t;

endpackage

// file: rtl/light_prox_result_and_threshold_logic.sv
`timescale 1ns/1ps
`default_nettype none
`include "light_prox_defs.svh"
// Functional notes
// - Conversion time code sets integration and resolution.
// - Gain code selects lux per count.
// - LED code zero disables driver, else current.
// - Ambient result right aligned, unused bits zero.
// - Overflow flag sits in high byte bit six.
// - Enabled overflow sets ambient status, pulls interrupt.
// - Ambient result follows mode: green, ir, difference.
// - Ambient result frozen during read until STOP.
// - Proximity result is read-only byte.
// - Proximity result frozen during read until STOP.
// - Fourteen-bit window limits, top high bits ignored.
// - Enabled ambient outside window counts persist events.
// - Persist codes need 1, 2, 4, 16 events.
// - Event-free conversion clears the persist counter.
// - Proximity persist uses its own field likewise.
// - Direction one: event when result above limit.
// - Direction zero: event when result below limit.
// - Trim registers read back complemented.
// - Green trim bits 7:1, infrared trim split.
// - Disabled channel skips compare, status stays low.
// - Status read or disable clears status, interrupt.
// - Interrupt pin open drain, pulls low pending.
module light_prox_result_and_threshold_logic #(
   // Slave address: the value is arbitrary.
   parameter logic [6:0] slave_addr = 7'h2a,
   parameter int unsigned amb_cyc_t0 = `AMB_T0_NS / `ADC_CLK_NS,
   parameter int unsigned amb_cyc_t1 = `AMB_T1_NS / `ADC_CLK_NS,
   parameter int unsigned amb_cyc_t2 = `AMB_T2_NS / `ADC_CLK_NS,
   parameter int unsigned amb_cyc_t3 = `AMB_T3_NS / `ADC_CLK_NS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic adc_clk,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   output logic irq_out,
   output logic irq_oe_n,
   input wire light_prox_pkg::fe_result_t fe_result,
   input wire logic fe_result_strobe,
   output light_prox_pkg::fe_cfg_t fe_cfg,
   output logic amb_integrate
);

   // ****************************************
   // Registers
   // ****************************************
   logic [7:0] main_cfg_r, rx_cfg_r, led_cfg_r, up_hi_r, up_lo_r, lo_hi_r, lo_lo_r;
   logic [7:0] persist_r, prox_dir_r, prox_lim_r, trim_g_r, trim_ir_r;
   logic [13:0] amb_latest_r, amb_vis_r;
   logic ovf_latest_r, ovf_vis_r;
   logic [7:0] prox_latest_r, prox_vis_r;
   logic amb_st_r, prox_st_r;
   logic [4:0] amb_cnt_r, prox_cnt_r;
   light_prox_pkg::fe_cfg_t cfg_r, cfg_meta_r, cfg_s2_r, cfg_s3_r;
   light_prox_pkg::fe_result_t hold_r, res_r;
   logic tog_r, tog_s1_r, tog_s2_r, tog_s3_r, res_vld_r;
   logic rst_l1_r, rst_l2_r;
   logic [19:0] int_cnt_r;
   logic scl_s1_r, scl_s2_r, scl_s3_r, sda_s1_r, sda_s2_r, sda_s3_r;
   light_prox_pkg::i2c_state_t st_r;
   logic [2:0] bit_cnt_r;
   logic [7:0] shift_r, tx_r, ptr_r, rd_byte;
   logic rw_r, lock_r;

   logic amb_en, prox_en, scl_rise, scl_fall, i2c_start, i2c_stop, wr_stb, st_rd;
   logic [7:0] wr_byte;
   light_prox_pkg::mode_t mode;
   logic [14:0] g_minus_ir;
   logic [13:0] amb_raw, amb_mask, amb_val, up_lim, lo_lim;
   logic amb_upd, prox_upd, amb_hit, prox_hit, amb_set, prox_set;
   logic [5:0] amb_step, prox_step;

   function automatic logic [5:0] persist_step(input logic [4:0] cnt, input logic [1:0] sel,
                                                input logic hit);
      logic [4:0] need;
      logic [4:0] c;
      begin
         unique case (sel)
            2'b00: need = `PERSIST_N0;
            2'b01: need = `PERSIST_N1;
            2'b10: need = `PERSIST_N2;
            2'b11: need = `PERSIST_N3;
         endcase
         c = (cnt >= need) ? cnt : cnt + 5'd1;
         persist_step = hit ? {(c >= need), c} : 6'h00;
      end
   endfunction

   function automatic logic [19:0] int_len(input logic [1:0] sel);
      begin
         unique case (sel)
            2'b00: int_len = 20'(amb_cyc_t0 - 1);
            2'b01: int_len = 20'(amb_cyc_t1 - 1);
            2'b10: int_len = 20'(amb_cyc_t2 - 1);
            2'b11: int_len = 20'(amb_cyc_t3 - 1);
         endcase
      end
   endfunction

   // ****************************************
   // Link domain: front end timing and result capture
   // ****************************************
   // The link side takes its own reset from rst_n through two flops.
   always_ff @(posedge adc_clk) begin
      rst_l1_r <= rst_n;
      rst_l2_r <= rst_l1_r;
   end

   // A word caught mid-change differs between the two later stages, so it is
   // only passed on once two samples agree.
   always_ff @(posedge adc_clk) begin
      cfg_meta_r <= cfg_r;
      cfg_s2_r <= cfg_meta_r;
      cfg_s3_r <= cfg_s2_r;
   end

   always_ff @(posedge adc_clk) begin
      if (cfg_s2_r == cfg_s3_r) begin
         fe_cfg <= cfg_s3_r;
      end
   end

   always_ff @(posedge adc_clk) begin
      if (!rst_l2_r) begin
         int_cnt_r <= 20'h00000;
         amb_integrate <= 1'b0;
      end else if (fe_cfg.mode == light_prox_pkg::MODE_SHUTDOWN ||
                   fe_cfg.mode == light_prox_pkg::MODE_PROX_ONLY) begin
         int_cnt_r <= 20'h00000;
         amb_integrate <= 1'b0;
      end else if (!amb_integrate) begin
         int_cnt_r <= int_len(fe_cfg.ambient_conv_time_sel);
         amb_integrate <= 1'b1;
      end else if (int_cnt_r == 20'h00000) begin
         amb_integrate <= 1'b0;
      end else begin
         int_cnt_r <= int_cnt_r - 20'h00001;
      end
   end

   // Held data must stay put until the toggle has crossed, so the front end
   // may not strobe again within about four clk periods.
   always_ff @(posedge adc_clk) begin
      if (!rst_l2_r) begin
         tog_r <= 1'b0;
         hold_r <= '0;
      end else if (fe_result_strobe) begin
         tog_r <= ~tog_r;
         hold_r <= fe_result;
      end
   end

   // ****************************************
   // Crossing into the register domain
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
         res_vld_r <= 1'b0;
         res_r <= '0;
      end else begin
         tog_s1_r <= tog_r;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
         res_vld_r <= tog_s2_r ^ tog_s3_r;
         if (tog_s2_r ^ tog_s3_r) begin
            res_r <= hold_r;
         end
      end
   end

   // ****************************************
   // Result shaping and comparison
   // ****************************************
   assign mode = light_prox_pkg::mode_t'(main_cfg_r[`MAIN_MODE_LSB +: 3]);
   assign amb_en = main_cfg_r[`MAIN_AMB_IE];
   assign prox_en = main_cfg_r[`MAIN_PROX_IE];
   assign up_lim = {up_hi_r[5:0], up_lo_r};
   assign lo_lim = {lo_hi_r[5:0], lo_lo_r};

   always_comb begin
      g_minus_ir = {1'b0, res_r.green} - {1'b0, res_r.ir};
      unique case (mode)
         light_prox_pkg::MODE_AMB_GREEN: amb_raw = res_r.green;
         light_prox_pkg::MODE_AMB_IR: amb_raw = res_r.ir;
         default: amb_raw = g_minus_ir[14] ? 14'h0000 : g_minus_ir[13:0];
      endcase
      unique case (rx_cfg_r[3:2])
         2'b00: amb_mask = 14'h3fff;
         2'b01: amb_mask = 14'h0fff;
         2'b10: amb_mask = 14'h03ff;
         2'b11: amb_mask = 14'h00ff;
      endcase
      amb_val = amb_raw & amb_mask;
      amb_upd = res_vld_r & res_r.amb_valid & (mode != light_prox_pkg::MODE_SHUTDOWN) &
                (mode <= light_prox_pkg::MODE_AMB_PROX);
      prox_upd = res_vld_r & res_r.prox_valid &
                 (mode == light_prox_pkg::MODE_AMB_PROX || mode == light_prox_pkg::MODE_PROX_ONLY);
      amb_hit = amb_en & ((amb_val > up_lim) | (amb_val < lo_lim));
      if (prox_dir_r[`PROX_DIR_BIT]) begin
         prox_hit = prox_en & (res_r.prox > prox_lim_r);
      end else begin
         prox_hit = prox_en & (res_r.prox < prox_lim_r);
      end
      amb_step = persist_step(amb_cnt_r, persist_r[`PERSIST_AMB_LSB +: 2], amb_hit);
      prox_step = persist_step(prox_cnt_r, persist_r[`PERSIST_PROX_LSB +: 2], prox_hit);
      amb_set = amb_upd & ((res_r.ovf & amb_en) | amb_step[5]);
      prox_set = prox_upd & prox_step[5];
   end

   // The newest conversion is always kept; only the visible copy freezes.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         amb_latest_r <= 14'h0000;
         ovf_latest_r <= 1'b0;
         prox_latest_r <= 8'h00;
         amb_vis_r <= 14'h0000;
         ovf_vis_r <= 1'b0;
         prox_vis_r <= 8'h00;
      end else begin
         if (amb_upd) begin
            amb_latest_r <= amb_val;
            ovf_latest_r <= res_r.ovf;
         end
         if (prox_upd) begin
            prox_latest_r <= res_r.prox;
         end
         if (!lock_r) begin
            amb_vis_r <= amb_latest_r;
            ovf_vis_r <= ovf_latest_r;
            prox_vis_r <= prox_latest_r;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         amb_cnt_r <= 5'd0;
      end else if (amb_upd) begin
         amb_cnt_r <= amb_step[4:0];
      end else if (st_rd | ~amb_en) begin
         amb_cnt_r <= 5'd0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prox_cnt_r <= 5'd0;
      end else if (prox_upd) begin
         prox_cnt_r <= prox_step[4:0];
      end else if (st_rd | ~prox_en) begin
         prox_cnt_r <= 5'd0;
      end
   end

   // A set in the cycle of a status read wins over the clear.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         amb_st_r <= 1'b0;
         prox_st_r <= 1'b0;
      end else begin
         amb_st_r <= amb_en & (amb_set | (amb_st_r & ~st_rd));
         prox_st_r <= prox_en & (prox_set | (prox_st_r & ~st_rd));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_out <= 1'b0;
         irq_oe_n <= 1'b1;
      end else begin
         irq_out <= 1'b0;
         irq_oe_n <= ~(amb_st_r | prox_st_r);
      end
   end

   // ****************************************
   // Serial register port
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         {scl_s1_r, scl_s2_r, scl_s3_r} <= 3'b111;
         {sda_s1_r, sda_s2_r, sda_s3_r} <= 3'b111;
      end else begin
         {scl_s1_r, scl_s2_r, scl_s3_r} <= {scl_in, scl_s1_r, scl_s2_r};
         {sda_s1_r, sda_s2_r, sda_s3_r} <= {sda_in, sda_s1_r, sda_s2_r};
      end
   end

   assign scl_rise = scl_s2_r & ~scl_s3_r;
   assign scl_fall = ~scl_s2_r & scl_s3_r;
   assign i2c_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
   assign i2c_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;
   assign wr_byte = {shift_r[6:0], sda_s2_r};
   assign wr_stb = scl_rise & (st_r == light_prox_pkg::I2C_WR) & (bit_cnt_r == 3'h7);
   assign st_rd = scl_rise & (st_r == light_prox_pkg::I2C_RD) & (bit_cnt_r == 3'h7) &
                  (ptr_r == `REG_STATUS);

   always_comb begin
      unique case (ptr_r)
         `REG_STATUS: rd_byte = {6'h00, prox_st_r, amb_st_r};
         `REG_MAIN_CFG: rd_byte = main_cfg_r;
         `REG_RX_CFG: rd_byte = rx_cfg_r;
         `REG_LED_CFG: rd_byte = led_cfg_r;
         `REG_AMB_HI: rd_byte = {1'b0, ovf_vis_r, amb_vis_r[13:8]};
         `REG_AMB_LO: rd_byte = amb_vis_r[7:0];
         `REG_UP_HI: rd_byte = up_hi_r;
         `REG_UP_LO: rd_byte = up_lo_r;
         `REG_LO_HI: rd_byte = lo_hi_r;
         `REG_LO_LO: rd_byte = lo_lo_r;
         `REG_PERSIST: rd_byte = persist_r;
         `REG_PROX_DIR: rd_byte = prox_dir_r;
         `REG_PROX_LIM: rd_byte = prox_lim_r;
         `REG_TRIM_G: rd_byte = ~trim_g_r;
         `REG_TRIM_IR: rd_byte = ~trim_ir_r;
         `REG_PROX_RES: rd_byte = prox_vis_r;
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= light_prox_pkg::I2C_IDLE;
         bit_cnt_r <= 3'h0;
         shift_r <= 8'h00;
         tx_r <= 8'h00;
         ptr_r <= 8'h00;
         rw_r <= 1'b0;
         lock_r <= 1'b0;
      end else if (i2c_stop) begin
         st_r <= light_prox_pkg::I2C_IDLE;
         lock_r <= 1'b0;
      end else if (i2c_start) begin
         st_r <= light_prox_pkg::I2C_ADDR;
         bit_cnt_r <= 3'h0;
      end else if (scl_rise) begin
         shift_r <= wr_byte;
         bit_cnt_r <= bit_cnt_r + 3'h1;
         unique case (st_r)
            light_prox_pkg::I2C_IDLE: bit_cnt_r <= 3'h0;
            light_prox_pkg::I2C_ADDR: if (bit_cnt_r == 3'h7) begin
               st_r <= (wr_byte[7:1] == slave_addr) ? light_prox_pkg::I2C_ADDR_ACK
                                                     : light_prox_pkg::I2C_IDLE;
               rw_r <= wr_byte[0];
            end
            light_prox_pkg::I2C_ADDR_ACK: begin
               bit_cnt_r <= 3'h0;
               tx_r <= rd_byte;
               if (rw_r) begin
                  lock_r <= 1'b1;
               end
               st_r <= rw_r ? light_prox_pkg::I2C_RD : light_prox_pkg::I2C_PTR;
            end
            light_prox_pkg::I2C_PTR: if (bit_cnt_r == 3'h7) begin
               ptr_r <= wr_byte;
               st_r <= light_prox_pkg::I2C_PTR_ACK;
            end
            light_prox_pkg::I2C_WR: if (bit_cnt_r == 3'h7) begin
               ptr_r <= ptr_r + 8'h01;
               st_r <= light_prox_pkg::I2C_WR_ACK;
            end
            light_prox_pkg::I2C_PTR_ACK, light_prox_pkg::I2C_WR_ACK: begin
               bit_cnt_r <= 3'h0;
               st_r <= light_prox_pkg::I2C_WR;
            end
            light_prox_pkg::I2C_RD: begin
               tx_r <= {tx_r[6:0], 1'b0};
               if (bit_cnt_r == 3'h7) begin
                  ptr_r <= ptr_r + 8'h01;
                  st_r <= light_prox_pkg::I2C_RD_ACK;
               end
            end
            light_prox_pkg::I2C_RD_ACK: begin
               bit_cnt_r <= 3'h0;
               tx_r <= rd_byte;
               st_r <= sda_s2_r ? light_prox_pkg::I2C_IDLE : light_prox_pkg::I2C_RD;
            end
            default: st_r <= light_prox_pkg::I2C_IDLE;
         endcase
      end
   end

   // SDA only changes after SCL falls, so data is stable over the high phase.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sda_out <= 1'b0;
         sda_oe_n <= 1'b1;
      end else begin
         sda_out <= 1'b0;
         if (i2c_stop || i2c_start) begin
            sda_oe_n <= 1'b1;
         end else if (scl_fall) begin
            sda_oe_n <= ~((st_r == light_prox_pkg::I2C_ADDR_ACK) |
                          (st_r == light_prox_pkg::I2C_PTR_ACK) |
                          (st_r == light_prox_pkg::I2C_WR_ACK) |
                          ((st_r == light_prox_pkg::I2C_RD) & ~tx_r[7]));
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         main_cfg_r <= `MAIN_CFG_RESET;
         {rx_cfg_r, led_cfg_r, persist_r, prox_dir_r, prox_lim_r} <= {5{`ZERO_RESET}};
         {up_hi_r, up_lo_r, lo_hi_r, lo_lo_r} <= {4{`ZERO_RESET}};
         trim_g_r <= `TRIM_RESET;
         trim_ir_r <= `TRIM_RESET;
      end else if (wr_stb) begin
         unique case (ptr_r)
            `REG_MAIN_CFG: main_cfg_r <= wr_byte;
            `REG_RX_CFG: rx_cfg_r <= wr_byte;
            `REG_LED_CFG: led_cfg_r <= {4'h0, wr_byte[3:0]};
            `REG_UP_HI: up_hi_r <= wr_byte;
            `REG_UP_LO: up_lo_r <= wr_byte;
            `REG_LO_HI: lo_hi_r <= wr_byte;
            `REG_LO_LO: lo_lo_r <= wr_byte;
            `REG_PERSIST: persist_r <= {4'h0, wr_byte[3:0]};
            `REG_PROX_DIR: prox_dir_r <= wr_byte;
            `REG_PROX_LIM: prox_lim_r <= wr_byte;
            `REG_TRIM_G: trim_g_r <= wr_byte;
            `REG_TRIM_IR: trim_ir_r <= wr_byte;
            default: ;
         endcase
      end
   end

   always_comb begin
      cfg_r.mode = mode;
      cfg_r.ambient_conv_time_sel = rx_cfg_r[3:2];
      cfg_r.ambient_gain_sel = rx_cfg_r[1:0];
      cfg_r.led_current_code = led_cfg_r[3:0];
      cfg_r.led_enable = (led_cfg_r[3:0] != 4'h0);
      cfg_r.green_trim = trim_g_r[7:1];
      cfg_r.infrared_channel_trim = {trim_ir_r, trim_g_r[0]};
      cfg_r.factory_trim = main_cfg_r[`MAIN_TRIM_SEL];
   end

   // ****************************************
   // Checks
   // ****************************************
   a_irq_pulls_low: assert property (
      @(posedge clk) disable iff (!rst_n) (amb_st_r | prox_st_r) |=> !irq_oe_n && !irq_out)
      else $error("interrupt pin not pulled low with status pending");
   a_irq_releases: assert property (
      @(posedge clk) disable iff (!rst_n) !(amb_st_r | prox_st_r) |=> irq_oe_n)
      else $error("interrupt pin held low without status");
   a_disabled_quiet: assert property (
      @(posedge clk) disable iff (!rst_n) !amb_en |=> !amb_st_r && amb_cnt_r == 5'd0)
      else $error("disabled ambient channel shows status or count");
   a_ovf_sets_status: assert property (
      @(posedge clk) disable iff (!rst_n) amb_upd && amb_en && res_r.ovf |=> amb_st_r ##1 !irq_oe_n)
      else $error("overflow did not raise ambient status and interrupt");
   a_read_clears: assert property (
      @(posedge clk) disable iff (!rst_n) st_rd && !amb_set |=> !amb_st_r)
      else $error("status read did not clear ambient status");
   a_amb_frozen: assert property (
      @(posedge clk) disable iff (!rst_n) lock_r |=> $stable(amb_vis_r) && $stable(ovf_vis_r))
      else $error("ambient result changed during a read");
   a_prox_frozen: assert property (
      @(posedge clk) disable iff (!rst_n) lock_r |=> $stable(prox_vis_r))
      else $error("proximity result changed during a read");
   a_persist_reset: assert property (
      @(posedge clk) disable iff (!rst_n) amb_upd && !amb_hit |=> amb_cnt_r == 5'd0)
      else $error("persist counter not cleared after quiet conversion");
   a_prox_above: assert property (
      @(posedge clk) disable iff (!rst_n) prox_upd && prox_en && prox_dir_r[`PROX_DIR_BIT] &&
      persist_r[3:2] == 2'b00 && res_r.prox > prox_lim_r |=> prox_st_r)
      else $error("proximity above limit did not set status");
   a_prox_below: assert property (
      @(posedge clk) disable iff (!rst_n) prox_upd && !prox_dir_r[`PROX_DIR_BIT] &&
      res_r.prox >= prox_lim_r |=> prox_cnt_r == 5'd0)
      else $error("proximity not below limit still counted");
   a_trim_complement: assert property (
      @(posedge clk) disable iff (!rst_n) ptr_r == `REG_TRIM_G |-> rd_byte == ~trim_g_r)
      else $error("trim register did not read back complemented");
   a_amb_resolution: assert property (
      @(posedge clk) disable iff (!rst_n) amb_upd && rx_cfg_r[3:2] == 2'b11 |=>
      amb_latest_r[13:8] == 6'h00)
      else $error("ambient result has bits beyond resolution");

endmodule
`default_nettype wire

// file: tb/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model #(
   parameter logic [6:0] dev_addr = 7'h2a
) (
   input wire logic clk,
   input wire logic sda_in,
   output logic scl,
   output logic sda_drv_n,
   output logic [7:0] rd_data,
   output logic rd_valid
);
   initial begin
      scl = 1'b1;
      sda_drv_n = 1'b1;
      rd_data = 8'h00;
      rd_valid = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // SDA moves three cycles after SCL falls, so the synchronised pins never show a false START.
   task automatic bit_io(input logic b, output logic s);
      hold(3);
      sda_drv_n = b;
      hold(7);
      scl = 1'b1;
      hold(5);
      s = sda_in;
      hold(5);
      scl = 1'b0;
   endtask
   task automatic cond(input logic first, input logic last);
      hold(3);
      sda_drv_n = first;
      hold(7);
      scl = 1'b1;
      hold(10);
      sda_drv_n = last;
      hold(10);
      scl = last;
   endtask
   task automatic put_byte(input logic [7:0] d);
      logic a;
      for (int i = 7; i >= 0; i--) bit_io(d[i], a);
      bit_io(1'b1, a);
   endtask
   task automatic access(input logic [7:0] p, input logic [7:0] d, input int n);
      logic [7:0] v;
      logic a;
      cond(1'b1, 1'b0);
      put_byte({dev_addr, 1'b0});
      put_byte(p);
      if (n == 0) put_byte(d);
      else cond(1'b1, 1'b0);
      if (n != 0) put_byte({dev_addr, 1'b1});
      for (int k = 0; k < n; k++) begin
         for (int i = 7; i >= 0; i--) bit_io(1'b1, v[i]);
         bit_io(k == n - 1, a);
         rd_data = v;
         rd_valid = 1'b1;
         hold(1);
         rd_valid = 1'b0;
      end
      cond(1'b0, 1'b1);
   endtask
endmodule
`default_nettype wire

// file: tb/light_prox_result_and_threshold_logic_tb.sv
`timescale 1ns/1ps
`default_nettype none
module light_prox_result_and_threshold_logic_tb;
   logic clk = 1'b0;
   logic adc_clk = 1'b0;
   logic rst_n, scl, sda_drv_n, sda_out, sda_oe_n, irq_out, irq_oe_n, rd_valid, fe_result_strobe;
   logic [7:0] rd_data;
   logic [13:0] g;
   logic [7:0] exp_q[$];
   light_prox_pkg::fe_result_t fe_result;
   int n_errors = 0;
   int check_count = 0;
   int seed = 32'ha567;
   wire sda = sda_drv_n & (sda_oe_n | sda_out);
   light_prox_result_and_threshold_logic #(.amb_cyc_t0(40), .amb_cyc_t1(20), .amb_cyc_t2(10),
      .amb_cyc_t3(5)) uut (.clk(clk), .rst_n(rst_n), .adc_clk(adc_clk), .scl_in(scl),
      .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .irq_out(irq_out),
      .irq_oe_n(irq_oe_n), .fe_result(fe_result), .fe_result_strobe(fe_result_strobe),
      .fe_cfg(), .amb_integrate());
   i2c_host_model host (.clk(clk), .sda_in(sda), .scl(scl), .sda_drv_n(sda_drv_n),
      .rd_data(rd_data), .rd_valid(rd_valid));
   initial forever #12.5 clk = ~clk;
   initial #7 forever #62.5 adc_clk = ~adc_clk;
   task automatic check(input string what, input logic [7:0] e, input logic [7:0] s);
      check_count++;
      if (e !== s) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic rd(input logic [7:0] p, input logic [7:0] e0, input logic [7:0] e1, input int n);
      exp_q.push_back(e0);
      if (n > 1) exp_q.push_back(e1);
      host.access(p, 8'h00, n);
   endtask
   task automatic fe(input logic [13:0] grn, input logic ovf, input logic [7:0] px);
      @(posedge adc_clk);
      #1;
      fe_result = {grn, 14'h0000, ovf, px, 2'b11};
      fe_result_strobe = 1'b1;
      @(posedge adc_clk);
      #1;
      fe_result_strobe = 1'b0;
      repeat (12) @(posedge adc_clk);
   endtask
   task automatic report_and_stop();
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge clk) if (rd_valid === 1'b1) check("read", exp_q.pop_front(), rd_data);
   initial begin
      #2000000;
      n_errors++;
      report_and_stop();
   end
   initial begin
      rst_n = 1'b0;
      fe_result = '0;
      fe_result_strobe = 1'b0;
      repeat (5) @(posedge clk);
      #1;
      rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      rd(8'h0f, 8'h7f, 8'h7f, 2);
      host.access(8'h0f, 8'h35, 0);
      rd(8'h0f, 8'hca, 8'h00, 1);
      host.access(8'h06, 8'hd0, 0);
      host.access(8'h01, 8'h05, 0);
      g = 14'($random(seed) & 32'h0fff);
      fe(g, 1'b0, 8'h00);
      rd(8'h04, {2'b00, g[13:8]}, g[7:0], 2);
      check("irq idle", 8'h01, {7'h00, irq_oe_n});
      fe(14'h1001, 1'b0, 8'h00);
      check("irq set", 8'h00, {7'h00, irq_oe_n});
      rd(8'h00, 8'h01, 8'h00, 1);
      check("irq clear", 8'h01, {7'h00, irq_oe_n});
      fe(14'h0005, 1'b1, 8'h00);
      rd(8'h04, 8'h40, 8'h05, 2);
      check("irq ovf", 8'h00, {7'h00, irq_oe_n});
      host.access(8'h0c, 8'h20, 0);
      host.access(8'h0b, 8'h40, 0);
      host.access(8'h01, 8'h12, 0);
      check("irq amb off", 8'h01, {7'h00, irq_oe_n});
      fe(14'h0000, 1'b0, 8'h30);
      check("irq prox above", 8'h00, {7'h00, irq_oe_n});
      rd(8'h16, 8'h30, 8'h00, 1);
      rd(8'h00, 8'h02, 8'h00, 1);
      host.access(8'h0b, 8'h00, 0);
      fe(14'h0000, 1'b0, 8'h10);
      check("irq prox below", 8'h00, {7'h00, irq_oe_n});
      report_and_stop();
   end
endmodule
`default_nettype wire
